// file: logic/charge_accumulator.sv
// Purpose: coulomb counter with bias, blanking, backup and temperature cell model
// Assumes: current_value holds the finished conversion result when a period ends
// Notes:   offset conversions cost one accumulation slot; a host write costs one, or two when made in a tick cycle
// How it works
// R1: add each conversion result at period end
// R2: sixteen-bit charge register, 6.25 uVh per bit
// R3: hidden fractional bits, never host visible
// R4: saturate at register maximum and minimum
// R5: positive results under 100 uV ignored
// R6: host writes high byte, then low byte
// R7: host write clears hidden fraction
// R8: host write forces an offset conversion
// R9: accumulation resumes at second conversion after write
// R10: back up charge, restore it at power-up
// R11: signed bias added once per conversion
// R12: bias restored from backup at power-up
// R13: bias bypasses blanking entirely
// R14: bias register at address 61h, signed
// R15: five segments, flat above forty degrees
// R16: segment four starts at forty degrees
// R17: breakpoints programmable -128 to +40 degrees
// R18: eight-bit slopes, 61 ppm per step
// R19: curves rebuilt in one-degree steps
// R20: curves normalised to full at forty degrees
// R21: conversion period is 3.52 seconds
// R22: discharge blanking only when enabled
// R23: linear stepping from forty degrees downward
// R24: offset conversion slot is not accumulated
`default_nettype none
module charge_accumulator
  import coulomb_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DOC
) (
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_write,
  input  wire logic signed [15:0] current_value,
  input  wire logic               discharge_blank_enable,
  input  wire logic signed [7:0]  temperature,
  input  wire logic [15:0]        nv_acr_in,
  input  wire logic [7:0]         nv_bias_in,
  output logic [7:0]              reg_rdata,
  output logic                    offset_request,
  output logic                    nv_save_strobe,
  output logic [15:0]             nv_acr_out,
  output logic [7:0]              nv_bias_out,
  output logic [15:0]             full_capacity,
  output logic [15:0]             active_empty_capacity,
  output logic [15:0]             standby_empty_capacity,
  output logic                    model_ready
);
  localparam logic [27:0] TMR_LAST = 28'(CONV_CYCLES - 1);

  slope_if slope_bus ();

  logic [27:0]           tmr_reg;
  logic                  tick_reg;
  logic [9:0]            slot_reg;
  logic                  init_reg;
  logic                  force_offset_reg;
  logic [15:0]           acr_reg;
  logic [FRAC_BITS-1:0]  frac_reg;
  logic [7:0]            acr_pend_reg;
  logic [7:0]            bias_reg;
  logic signed [7:0]     bp12_reg;
  logic signed [7:0]     bp23_reg;
  logic signed [7:0]     bp34_reg;
  logic [15:0]           full40_reg;
  logic [15:0]           ae40_reg;
  logic [7:0]            reg_rdata_reg;
  logic                  offset_request_reg;
  logic                  nv_save_strobe_reg;
  logic [15:0]           nv_acr_out_reg;
  logic [7:0]            nv_bias_out_reg;
  logic                  offset_slot;
  logic                  lsb_write;
  logic                  acc_en;
  logic signed [15:0]    cur_eff;
  logic signed [29:0]    acc_sum;
  logic [27:0]           acc_next;
  logic signed [7:0]     bp_wdata;
  logic [7:0]            slope_idx;
  model_state_t          mdl_state_reg;
  logic signed [7:0]     t_reg;
  logic signed [7:0]     tgt_reg;
  logic [15:0]           full_reg;
  logic [15:0]           ae_reg;
  logic [15:0]           se_reg;
  logic [15:0]           full_capacity_reg;
  logic [15:0]           ae_capacity_reg;
  logic [15:0]           se_capacity_reg;
  logic                  model_ready_reg;
  logic [31:0]           ae_prod;
  logic [9:0]            d_full;
  logic [9:0]            d_ae;
  logic [9:0]            d_se;
  logic [16:0]           full_sub;
  logic [16:0]           ae_add;
  logic [16:0]           se_add;

  slope_table u_slope_table (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tbl     (slope_bus.store)
  );

  // conversion time base; the current result is taken as final on the tick
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tmr_reg  <= 28'h0000000;
      tick_reg <= 1'b0;
    end else if (tmr_reg == TMR_LAST) begin
      tmr_reg  <= 28'h0000000;
      tick_reg <= 1'b1; // [R21]
    end else begin
      tmr_reg  <= tmr_reg + 28'h0000001;
      tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      slot_reg <= 10'h000;
    end else if (tick_reg) begin
      slot_reg <= slot_reg + 10'h001;
    end
  end

  // high through reset and the first cycle after, when backups are caught
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      init_reg <= 1'b1;
    end else begin
      init_reg <= 1'b0;
    end
  end

  assign lsb_write   = reg_write && (reg_addr == ADDR_ACR_LSB) && !init_reg;
  assign offset_slot = force_offset_reg || (slot_reg == OFFSET_SLOT);
  // a write in the tick cycle takes the slot as well
  assign acc_en      = tick_reg && !offset_slot && !lsb_write; // [R1] [R24] [R9]

  // set wins over the tick that would clear it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      force_offset_reg <= 1'b0;
    end else if (lsb_write) begin
      force_offset_reg <= 1'b1; // [R8]
    end else if (tick_reg) begin
      force_offset_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      offset_request_reg <= 1'b0;
    end else begin
      offset_request_reg <= tick_reg && offset_slot; // [R8]
    end
  end

  always_comb begin
    cur_eff = current_value;
    if (current_value > 16'sh0000 && current_value < CHG_BLANK) begin
      cur_eff = 16'sh0000; // [R5]
    end
    if (discharge_blank_enable && current_value < 16'sh0000 && current_value > -DIS_BLANK) begin
      cur_eff = 16'sh0000; // [R22]
    end
    // bias joins after blanking, so small biases still count
    acc_sum = $signed({2'b00, acr_reg, frac_reg}) + 30'(cur_eff)
            + 30'($signed(bias_reg)); // [R11] [R13]
    if (acc_sum < 30'sh00000000) begin
      acc_next = 28'h0000000; // [R4]
    end else if (acc_sum > $signed({2'b00, ACR_MAX, {FRAC_BITS{1'b1}}})) begin
      acc_next = {ACR_MAX, {FRAC_BITS{1'b1}}}; // [R4]
    end else begin
      acc_next = acc_sum[27:0];
    end
  end

  // high byte waits here until the low byte commits the pair
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acr_pend_reg <= 8'h00;
    end else if (reg_write && reg_addr == ADDR_ACR_MSB) begin
      acr_pend_reg <= reg_wdata; // [R6]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acr_reg  <= ACR_RST;
      frac_reg <= '0;
    end else if (init_reg) begin
      acr_reg  <= nv_acr_in; // [R10]
      frac_reg <= '0;
    end else if (lsb_write) begin
      acr_reg  <= {acr_pend_reg, reg_wdata}; // [R6]
      frac_reg <= '0; // [R7]
    end else if (acc_en) begin
      {acr_reg, frac_reg} <= acc_next; // [R1] [R2] [R3]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bias_reg <= BIAS_RST;
    end else if (init_reg) begin
      bias_reg <= nv_bias_in; // [R12]
    end else if (reg_write && reg_addr == ADDR_BIAS) begin
      bias_reg <= reg_wdata; // [R14]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nv_save_strobe_reg <= 1'b0;
      nv_acr_out_reg     <= ACR_RST;
      nv_bias_out_reg    <= BIAS_RST;
    end else begin
      nv_save_strobe_reg <= tick_reg && (slot_reg[5:0] == NV_SAVE_SLOT); // [R10]
      if (tick_reg && slot_reg[5:0] == NV_SAVE_SLOT) begin
        nv_acr_out_reg  <= acr_reg;
        nv_bias_out_reg <= bias_reg;
      end
    end
  end

  // breakpoints above the flat segment are pulled back to its edge
  assign bp_wdata = ($signed(reg_wdata) > MODEL_TOP) ? MODEL_TOP : $signed(reg_wdata); // [R17]

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bp12_reg   <= BP_RST;
      bp23_reg   <= BP_RST;
      bp34_reg   <= BP_RST;
      full40_reg <= CELL_RST;
      ae40_reg   <= CELL_RST;
    end else if (reg_write) begin
      unique case (reg_addr)
        ADDR_BP12:       bp12_reg <= bp_wdata; // [R17]
        ADDR_BP23:       bp23_reg <= bp_wdata;
        ADDR_BP34:       bp34_reg <= bp_wdata;
        ADDR_FULL40_MSB: full40_reg[15:8] <= reg_wdata; // [R20]
        ADDR_FULL40_LSB: full40_reg[7:0]  <= reg_wdata;
        ADDR_AE40_MSB:   ae40_reg[15:8]   <= reg_wdata;
        ADDR_AE40_LSB:   ae40_reg[7:0]    <= reg_wdata;
        default: ;
      endcase
    end
  end

  // slope addresses: curve in idx[3:2], segment in idx[1:0]
  assign slope_idx = reg_addr - ADDR_SLOPE_BASE;
  assign slope_bus.wr_seg  = slope_idx[1:0];
  assign slope_bus.wr_data = reg_wdata;
  assign slope_bus.wr_lane = (reg_write && reg_addr >= ADDR_SLOPE_BASE
                              && slope_idx < SLOPE_COUNT)
                             ? 3'(3'b001 << slope_idx[3:2]) : 3'b000; // [R18]

  // segment of the degree below t_reg: four is nearest forty
  always_comb begin
    if (t_reg > bp34_reg) begin
      slope_bus.rd_seg = 2'd3; // [R16]
    end else if (t_reg > bp23_reg) begin
      slope_bus.rd_seg = 2'd2;
    end else if (t_reg > bp12_reg) begin
      slope_bus.rd_seg = 2'd1;
    end else begin
      slope_bus.rd_seg = 2'd0; // [R16]
    end
  end

  // 61 ppm is close to 2^-14 of the forty-degree full value
  always_comb begin
    d_full   = 10'((24'(full40_reg) * 24'(slope_bus.rd_data[7:0])) >> SLOPE_SHIFT); // [R18]
    d_ae     = 10'((24'(full40_reg) * 24'(slope_bus.rd_data[15:8])) >> SLOPE_SHIFT);
    d_se     = 10'((24'(full40_reg) * 24'(slope_bus.rd_data[23:16])) >> SLOPE_SHIFT);
    full_sub = {1'b0, full_reg} - 17'(d_full);
    ae_add   = {1'b0, ae_reg} + 17'(d_ae);
    se_add   = {1'b0, se_reg} + 17'(d_se);
    ae_prod  = 32'(full40_reg) * 32'(ae40_reg);
  end

  // full falls and both empties rise toward colder temperatures
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mdl_state_reg <= MDL_IDLE;
      t_reg         <= MODEL_TOP;
      tgt_reg       <= MODEL_TOP;
      full_reg      <= CELL_RST;
      ae_reg        <= CELL_RST;
      se_reg        <= CELL_RST;
    end else begin
      unique case (mdl_state_reg)
        MDL_IDLE: begin
          if (tick_reg || init_reg) begin
            t_reg    <= MODEL_TOP; // [R20] [R23]
            tgt_reg  <= temperature;
            full_reg <= full40_reg;
            ae_reg   <= (ae_prod[31:26] != 6'h00) ? 16'hffff : ae_prod[25:AE_SHIFT];
            se_reg   <= CELL_RST; // [R20]
            if (temperature < MODEL_TOP) begin
              mdl_state_reg <= MDL_READ;
            end
          end
        end
        MDL_READ: mdl_state_reg <= MDL_STEP;
        MDL_STEP: begin
          full_reg <= full_sub[16] ? 16'h0000 : full_sub[15:0]; // [R19] [R23]
          ae_reg   <= ae_add[16] ? 16'hffff : ae_add[15:0];
          se_reg   <= se_add[16] ? 16'hffff : se_add[15:0];
          t_reg    <= t_reg - 8'sh01; // [R19]
          mdl_state_reg <= (t_reg - 8'sh01 == tgt_reg) ? MDL_IDLE : MDL_READ;
        end
        default: mdl_state_reg <= MDL_IDLE;
      endcase
    end
  end

  // results publish when a walk ends or on a flat-segment update with no walk, never mid-walk
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      full_capacity_reg <= CELL_RST;
      ae_capacity_reg   <= CELL_RST;
      se_capacity_reg   <= CELL_RST;
      model_ready_reg   <= 1'b0;
    end else if (mdl_state_reg == MDL_IDLE && (tick_reg || init_reg)
                 && temperature >= MODEL_TOP) begin
      full_capacity_reg <= full40_reg; // [R15]
      ae_capacity_reg   <= (ae_prod[31:26] != 6'h00) ? 16'hffff : ae_prod[25:AE_SHIFT];
      se_capacity_reg   <= CELL_RST;
      model_ready_reg   <= 1'b1;
    end else if (mdl_state_reg == MDL_STEP && t_reg - 8'sh01 == tgt_reg) begin
      full_capacity_reg <= full_sub[16] ? 16'h0000 : full_sub[15:0];
      ae_capacity_reg   <= ae_add[16] ? 16'hffff : ae_add[15:0];
      se_capacity_reg   <= se_add[16] ? 16'hffff : se_add[15:0];
      model_ready_reg   <= 1'b1;
    end
  end

  // fraction bits have no address
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata_reg <= 8'h00;
    end else begin
      unique case (reg_addr)
        ADDR_ACR_MSB:    reg_rdata_reg <= acr_reg[15:8]; // [R3]
        ADDR_ACR_LSB:    reg_rdata_reg <= acr_reg[7:0];
        ADDR_BIAS:       reg_rdata_reg <= bias_reg; // [R14]
        ADDR_BP12:       reg_rdata_reg <= bp12_reg;
        ADDR_BP23:       reg_rdata_reg <= bp23_reg;
        ADDR_BP34:       reg_rdata_reg <= bp34_reg;
        ADDR_FULL40_MSB: reg_rdata_reg <= full40_reg[15:8];
        ADDR_FULL40_LSB: reg_rdata_reg <= full40_reg[7:0];
        ADDR_AE40_MSB:   reg_rdata_reg <= ae40_reg[15:8];
        ADDR_AE40_LSB:   reg_rdata_reg <= ae40_reg[7:0];
        default:         reg_rdata_reg <= 8'h00;
      endcase
    end
  end

  assign reg_rdata              = reg_rdata_reg;
  assign offset_request         = offset_request_reg;
  assign nv_save_strobe         = nv_save_strobe_reg;
  assign nv_acr_out             = nv_acr_out_reg;
  assign nv_bias_out            = nv_bias_out_reg;
  assign full_capacity          = full_capacity_reg;
  assign active_empty_capacity  = ae_capacity_reg;
  assign standby_empty_capacity = se_capacity_reg;
  assign model_ready            = model_ready_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence acr_commit;
    reg_write && reg_addr == ADDR_ACR_LSB && !init_reg;
  endsequence
  sequence quiet_slot;
    tick_reg && !offset_slot && !reg_write;
  endsequence

  chk_write_clears: assert property (acr_commit |=> frac_reg == '0 // [R7]
    && acr_reg == {$past(acr_pend_reg), $past(reg_wdata)}) else $error("acr write not taken");
  chk_write_offset: assert property (acr_commit ##1 (tick_reg && !reg_write)[*1] // [R8]
    |=> offset_request_reg) else $error("no offset request after acr write");
  chk_skip_slot: assert property (tick_reg && force_offset_reg && !reg_write // [R9]
    |=> $stable(acr_reg) && $stable(frac_reg)) else $error("accumulated in offset slot");
  chk_charge_blank: assert property (quiet_slot and (current_value > 16'sh0000 // [R5]
    && current_value < CHG_BLANK && bias_reg == 8'h00)
    |=> $stable(acr_reg) && $stable(frac_reg)) else $error("small charge accumulated");
  chk_discharge_blank: assert property (quiet_slot and (discharge_blank_enable // [R22]
    && current_value < 16'sh0000 && current_value > -DIS_BLANK && bias_reg == 8'h00)
    |=> $stable(acr_reg) && $stable(frac_reg)) else $error("small discharge accumulated");
  chk_bias_add: assert property (quiet_slot and (current_value == 16'sh0000 // [R11]
    && !bias_reg[7] && acr_reg < 16'hfff0)
    |=> {acr_reg, frac_reg} == $past({acr_reg, frac_reg}) + 28'($past(bias_reg)))
    else $error("bias not added");
  chk_sat_top: assert property (acc_en && acc_sum > $signed({2'b00, ACR_MAX, // [R4]
    {FRAC_BITS{1'b1}}}) |=> acr_reg == ACR_MAX) else $error("no saturation at top");
  // init_reg is already high inside reset; only the released cycle loads backups
  chk_restore: assert property (init_reg && !reset |=> acr_reg == $past(nv_acr_in) // [R10] [R12]
    && bias_reg == $past(nv_bias_in)) else $error("backup not restored");
  chk_tick_gap: assert property (tick_reg |=> !tick_reg [*2]) // [R21]
    else $error("conversion ticks too close");
  chk_model_flat: assert property (mdl_state_reg == MDL_IDLE && tick_reg // [R15]
    && temperature >= MODEL_TOP |=> full_capacity_reg == $past(full40_reg)
    && standby_empty_capacity == 16'h0000) else $error("flat segment not flat");
  chk_model_step: assert property (mdl_state_reg == MDL_STEP // [R19]
    |=> t_reg == $past(t_reg) - 8'sh01 && mdl_state_reg != MDL_STEP)
    else $error("model walk not one degree");
endmodule
`default_nettype wire

// file: logic/coulomb_pkg.sv
// Purpose: shared constants and types for the charge accumulator and cell model
// Assumes: byte-wide register port, 50 MHz sys_clk
// Notes:   current and bias share a weight of 1.5625 uV per bit
`default_nettype none
package coulomb_pkg;
  localparam logic [7:0] ADDR_ACR_MSB    = 8'h10;
  localparam logic [7:0] ADDR_ACR_LSB    = 8'h11;
  localparam logic [7:0] ADDR_BIAS       = 8'h61;
  localparam logic [7:0] ADDR_BP12       = 8'h70;
  localparam logic [7:0] ADDR_BP23       = 8'h71;
  localparam logic [7:0] ADDR_BP34       = 8'h72;
  localparam logic [7:0] ADDR_FULL40_MSB = 8'h73;
  localparam logic [7:0] ADDR_FULL40_LSB = 8'h74;
  localparam logic [7:0] ADDR_AE40_MSB   = 8'h75;
  localparam logic [7:0] ADDR_AE40_LSB   = 8'h76;
  localparam logic [7:0] ADDR_SLOPE_BASE = 8'h78;
  localparam logic [7:0] SLOPE_COUNT     = 8'h0c;
  localparam int         FRAC_BITS       = 12;
  localparam logic [15:0] ACR_RST        = 16'h0000;
  localparam logic [15:0] ACR_MAX        = 16'hffff;
  localparam logic [7:0]  BIAS_RST       = 8'h00;
  localparam logic [7:0]  BP_RST         = 8'h00;
  localparam logic [15:0] CELL_RST       = 16'h0000;
  localparam logic signed [15:0] CHG_BLANK = 16'sh0040;
  localparam logic signed [15:0] DIS_BLANK = 16'sh0010;
  localparam logic signed [7:0]  MODEL_TOP = 8'sh28;
  localparam int         SLOPE_SHIFT     = 14;
  localparam int         AE_SHIFT        = 10;
  localparam logic [9:0] OFFSET_SLOT     = 10'h3ff;
  localparam logic [5:0] NV_SAVE_SLOT    = 6'h00;
  localparam int         CONV_TIME_MS    = 3520;
  localparam int         CLK_HZ          = 50000000;
  localparam int         CONV_CYCLES_DOC = CONV_TIME_MS * (CLK_HZ / 1000);
  typedef enum logic [2:0] {
    MDL_IDLE = 3'b001,
    MDL_READ = 3'b010,
    MDL_STEP = 3'b100
  } model_state_t;
endpackage
`default_nettype wire

// file: logic/slope_if.sv
// Purpose: carries slope table writes and reads between accumulator and table
// Assumes: one registered read per cycle
// Notes:   a word holds full, active-empty and standby-empty slopes of one segment
`default_nettype none
interface slope_if;
  logic [1:0]  wr_seg;
  logic [2:0]  wr_lane;
  logic [7:0]  wr_data;
  logic [1:0]  rd_seg;
  logic [23:0] rd_data;
  modport owner (output wr_seg, output wr_lane, output wr_data, output rd_seg, input rd_data);
  modport store (input wr_seg, input wr_lane, input wr_data, input rd_seg, output rd_data);
endinterface
`default_nettype wire

// file: logic/slope_table.sv
// Purpose: four-segment slope store, one byte lane per model curve
// Assumes: lane 0 full, lane 1 active empty, lane 2 standby empty
// Notes:   read data is registered, so a new segment appears one cycle later
`default_nettype none
module slope_table
  import coulomb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  slope_if.store   tbl
);
  logic [7:0] rd_lane [3];

  for (genvar l = 0; l < 3; l++) begin : g_lane
    logic [7:0] lane_mem [4];
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        for (int s = 0; s < 4; s++) begin
          lane_mem[s] <= 8'h00;
        end
      end else if (tbl.wr_lane[l]) begin
        lane_mem[tbl.wr_seg] <= tbl.wr_data;
      end
    end
    always_ff @(posedge sys_clk) begin
      rd_lane[l] <= lane_mem[tbl.rd_seg];
    end
  end

  assign tbl.rd_data = {rd_lane[2], rd_lane[1], rd_lane[0]};
endmodule
`default_nettype wire

// file: verif/adc_model.sv
// Purpose: current converter stand-in feeding finished results to the accumulator
// Assumes: result held stable between conversions, registered on sys_clk
// Notes:   offset conversions are only counted; the held result is kept
`default_nettype none
module adc_model (
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic               offset_request,
  input  wire logic signed [15:0] level,
  output var  logic signed [15:0] current_value,
  output var  int                 offset_count
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge sys_clk) begin
    current_value <= level;
    if (reset) begin
      offset_count <= 0;
    end else if (offset_request) begin
      offset_count <= offset_count + 1;
    end
  end
endmodule
`default_nettype wire

// file: verif/tb.sv
// Purpose: self-checking bench for the charge accumulator
// Assumes: short conversion period, host writes through the byte register port
// Notes:   expected charge tracked with the hidden fraction bits included
`default_nettype none
module tb
  import coulomb_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 40;
  // segment-four full slope of 40h over two one-degree steps below the top
  localparam logic [31:0] FULL_COLD = 32'h1234 - 2 * ((32'h1234 * 32'h40) >> SLOPE_SHIFT);
  logic               sys_clk = 1'b0;
  logic               reset = 1'b1;
  logic [7:0]         reg_addr = 8'h00;
  logic [7:0]         reg_wdata = 8'h00;
  logic               reg_write = 1'b0;
  logic signed [15:0] level = 16'sh0000;
  logic               discharge_blank_enable = 1'b0;
  logic signed [7:0]  temperature = 8'sh32;
  logic [15:0]        nv_acr_in = 16'h1234;
  logic [7:0]         nv_bias_in = 8'h05;
  logic signed [15:0] current_value;
  logic [7:0]         reg_rdata, nv_bias_out;
  logic               offset_request, nv_save_strobe, model_ready;
  logic [15:0]        nv_acr_out, full_capacity, active_empty_capacity, standby_empty_capacity;
  int                 offset_count, k;
  int                 fails = 0;
  int                 samples_checked = 0;
  int                 runs = 0;
  always #10 sys_clk = ~sys_clk;
  charge_accumulator #(.CONV_CYCLES(CONV)) dut_u (
    .sys_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .current_value,
    .discharge_blank_enable, .temperature, .nv_acr_in, .nv_bias_in, .reg_rdata,
    .offset_request, .nv_save_strobe, .nv_acr_out, .nv_bias_out, .full_capacity,
    .active_empty_capacity, .standby_empty_capacity, .model_ready);
  adc_model adc_u (.sys_clk, .reset, .offset_request, .level, .current_value,
    .offset_count);
  task automatic summarize;
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  // read data is registered: show the address, let one edge take it
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    @(posedge sys_clk);
    #1 check(what, {24'h0, reg_rdata}, {24'h0, exp});
  endtask
  task automatic wait_pulse(input bit save, input int limit);
    for (int n = 0; n <= limit; n++) begin
      @(posedge sys_clk);
      #1;
      if ((save ? nv_save_strobe : offset_request) === 1'b1) return;
    end
    fails++;
    $display("[ERR] pulse wait expected 1 seen timeout");
    summarize();
  endtask
  // one conversion: blank small charge always, small discharge when enabled,
  // then add the bias unblanked and clamp the 16.12 total
  function automatic logic [27:0] step(input logic [27:0] a, input logic signed [15:0] i,
                                       input logic signed [7:0] b, input logic en);
    int v;
    v = int'(i);
    if ((v > 0 && v < 64) || (en && v < 0 && v > -16)) v = 0;
    v = int'(a) + v + int'(b);
    if (v < 0) v = 0;
    if (v > 32'h0fffffff) v = 32'h0fffffff;
    return v[27:0];
  endfunction
  task automatic acc_run(input logic [15:0] a, input logic signed [15:0] i,
                         input logic [7:0] b, input logic en, input int n);
    logic [27:0] e;
    e = {a, 12'h000};
    level <= i;
    discharge_blank_enable <= en;
    runs++;
    wr(ADDR_BIAS, b);
    rd_chk("bias", ADDR_BIAS, b);
    wr(ADDR_ACR_MSB, a[15:8]);
    wr(ADDR_ACR_LSB, a[7:0]);
    wait_pulse(1'b0, 2 * CONV + 4);
    rd_chk("acr_hi_skip", ADDR_ACR_MSB, a[15:8]);
    for (int t = 0; t < n; t++) e = step(e, i, b, en);
    repeat (CONV * n - 2) @(posedge sys_clk);
    rd_chk("acr_hi", ADDR_ACR_MSB, e[27:20]);
    rd_chk("acr_lo", ADDR_ACR_LSB, e[19:12]);
    $display("test acc %h %0d done", a, i);
  endtask
  initial begin
    void'($urandom(32'h2e54));
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd_chk("restore_hi", ADDR_ACR_MSB, 8'h12);
    rd_chk("restore_lo", ADDR_ACR_LSB, 8'h34);
    rd_chk("restore_bias", ADDR_BIAS, 8'h05);
    wr(ADDR_BP12, 8'h50);
    rd_chk("bp_clamp", ADDR_BP12, 8'h28);
    wr(ADDR_BP23, 8'h80);
    rd_chk("bp_min", ADDR_BP23, 8'h80);
    rd_chk("slope_wo", ADDR_SLOPE_BASE, 8'h00);
    rd_chk("unmapped", 8'h05, 8'h00);
    $display("test registers done");
    acc_run(16'h0100, 16'sd63, 8'h00, 1'b0, 2);
    acc_run(16'h0100, 16'sd4096, 8'h00, 1'b0, 3);
    acc_run(16'h0100, -16'sd15, 8'h00, 1'b1, 2);
    acc_run(16'h0100, -16'sd15, 8'h00, 1'b0, 2);
    acc_run(16'h0100, -16'sd16, 8'h00, 1'b1, 1);
    acc_run(16'h0100, 16'sd63, 8'hff, 1'b0, 1);
    acc_run(16'hfffe, 16'sd32767, 8'h7f, 1'b0, 2);
    acc_run(16'h0001, -16'sd32768, 8'h80, 1'b0, 2);
    acc_run(16'h0100, 16'sd0, 8'h03, 1'b0, 2);
    for (k = 0; k < 8; k++)
      acc_run(16'($urandom), 16'($urandom), 8'($urandom), 1'($urandom), 1 + $urandom % 3);
    check("offset_count", 32'(offset_count), 32'(runs));
    acc_run(16'h4321, 16'sd0, 8'h00, 1'b0, 1);
    wait_pulse(1'b1, 64 * CONV + 8);
    check("nv_acr", {16'h0, nv_acr_out}, 32'h4321);
    check("nv_bias", {24'h0, nv_bias_out}, 32'h0);
    $display("test backup done");
    wr(ADDR_FULL40_MSB, 8'h12);
    wr(ADDR_FULL40_LSB, 8'h34);
    wr(ADDR_AE40_MSB, 8'h02);
    wr(ADDR_AE40_LSB, 8'h00);
    repeat (3 * CONV) @(posedge sys_clk);
    #1 check("model_ready", {31'h0, model_ready}, 32'h1);
    check("full_hot", {16'h0, full_capacity}, 32'h1234);
    check("ae_hot", {16'h0, active_empty_capacity}, (32'h1234 * 32'h200) >> AE_SHIFT);
    check("standby_hot", {16'h0, standby_empty_capacity}, 32'h0);
    temperature <= 8'sh26;
    wr(ADDR_SLOPE_BASE + 8'h03, 8'h40);
    repeat (3 * CONV) @(posedge sys_clk);
    #1 check("full_cold", {16'h0, full_capacity}, FULL_COLD);
    $display("test model done");
    summarize();
  end
endmodule
`default_nettype wire
